// [inc/scw_ifs.sv]
// interfaces between the top and its config port and exposure timer
// assumes the config side toggles its request only once per spi frame
interface scw_cfg_if;
   import scw_pkg::*;
   logic             req_toggle;
   logic             is_write;
   logic [6:0]       addr;
   logic [7:0]       wdata;
   logic             ack_toggle;
   logic [7:0]       rdata;
   modport port (output req_toggle, is_write, addr, wdata, input ack_toggle, rdata);
   modport regs (input req_toggle, is_write, addr, wdata, output ack_toggle, rdata);
endinterface : scw_cfg_if

interface scw_exp_if;
   import scw_pkg::*;
   logic             ext_mode;
   logic [23:0]      exp_count;
   logic [7:0]       spl;
   logic             ro_busy;
   logic             integrating;
   logic             fot_active;
   logic             readout_start;
   logic             exp_busy;
   modport seq (input ext_mode, exp_count, spl, ro_busy,
                output integrating, fot_active, readout_start, exp_busy);
   modport ctl (output ext_mode, exp_count, spl, ro_busy,
                input integrating, fot_active, readout_start, exp_busy);
endinterface : scw_exp_if

// [inc/scw_pkg.sv]
// constants, register map and state types of the control-word block
// assumes one master clock, one pixel and one control word per period
package scw_pkg;

   // ==========================================================
   // register map
   localparam int          REG_AW        = 7;
   localparam logic [6:0]  REG_EXP_SRC   = 7'h29;
   localparam logic [6:0]  REG_EXP_CNT0  = 7'h2a;
   localparam logic [6:0]  REG_EXP_CNT1  = 7'h2b;
   localparam logic [6:0]  REG_EXP_CNT2  = 7'h2c;
   localparam logic [6:0]  REG_SPL       = 7'h49;
   localparam logic [6:0]  REG_TRAIN_LO  = 7'h4e;
   localparam logic [6:0]  REG_TRAIN_HI  = 7'h4f;
   localparam logic [6:0]  REG_TPA_SEL   = 7'h6c;
   localparam logic [6:0]  REG_TPB_SEL   = 7'h6d;
   localparam logic [6:0]  REG_OUT_MODE  = 7'h70;
   localparam logic [6:0]  REG_ROWS_LO   = 7'h71;
   localparam logic [6:0]  REG_ROWS_HI   = 7'h72;
   localparam logic [6:0]  REG_STATUS    = 7'h73;

   // ==========================================================
   // reset values
   localparam logic        EXP_SRC_RST   = 1'b0;
   localparam logic [23:0] EXP_CNT_RST   = 24'h00_0800;
   localparam logic [7:0]  SPL_RST       = 8'h0a;
   localparam logic [11:0] TRAIN_RST     = 12'h3a5;
   localparam logic [7:0]  TSEL_RST      = 8'h00;
   localparam logic [7:0]  OUT_MODE_RST  = 8'h00;
   localparam logic [11:0] ROWS_RST      = 12'h800;

   // ==========================================================
   // fields
   localparam int          OM_MUX_LSB    = 0;
   localparam int          OM_WIDTH12    = 2;
   localparam int          CW_W          = 12;
   localparam int          CW_DATA_VALID_FLAG       = 0;
   localparam int          CW_LINE_VALID_FLAG       = 1;
   localparam int          CW_FRAME_VALID_FLAG       = 2;
   localparam int          CW_SLOT       = 3;
   localparam int          CW_ROW        = 4;
   localparam int          CW_FOT        = 5;
   localparam int          CW_INT1       = 6;
   localparam int          CW_INT2       = 7;
   localparam logic [11:0] CW_CONST      = 12'h200;
   localparam logic [7:0]  TSEL_INT1     = 8'h00;
   localparam logic [7:0]  TSEL_INT2     = 8'h01;
   localparam logic [7:0]  TSEL_DATA_VALID_FLAG     = 8'h02;
   localparam logic [7:0]  TSEL_LINE_VALID_FLAG     = 8'h03;
   localparam logic [7:0]  TSEL_FRAME_VALID_FLAG     = 8'h04;

   // ==========================================================
   // timing counts in master clock periods, spi bit counts in sclk periods
   localparam logic [7:0]  EXP_UNIT_LAST = 8'h80;
   localparam logic [6:0]  BURST_LAST    = 7'h7f;
   localparam logic [3:0]  SPI_LAST_BIT  = 4'hf;
   localparam logic [3:0]  SPI_RD_FIRST  = 4'h7;

   // ==========================================================
   // states
   typedef enum logic [1:0] {RO_IDLE, RO_ROW, RO_SLOT, RO_BURST} scw_ro_state_t;
   typedef enum logic [1:0] {EX_IDLE, EX_EXPOSE, EX_FOT} scw_ex_state_t;

endpackage : scw_pkg

// [rtl/scw_exposure.sv]
// exposure timer: internal count or external pin interval, then fot
// assumes pins are asynchronous to sys_clk
module scw_exposure
   import scw_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic exposure_start_pin,
   input  wire logic frame_request_pin,
   scw_exp_if.seq    exp
);
   scw_ex_state_t state_q, state_d;
   logic [2:0]  start_sync_q, start_sync_d;
   logic [2:0]  req_sync_q, req_sync_d;
   logic [7:0]  cyc_q, cyc_d;
   logic [23:0] units_q, units_d;
   logic        pend_q, pend_d;
   logic        integ_q, integ_d;
   logic        fot_q, fot_d;
   logic        ro_start_q, ro_start_d;
   logic        start_rise, req_rise, tick;
   logic [23:0] exp_last;
   logic [23:0] fot_last;

   assign start_rise = start_sync_q[1] & ~start_sync_q[2];
   assign req_rise   = req_sync_q[1] & ~req_sync_q[2];
   assign tick       = (cyc_q == EXP_UNIT_LAST);
   assign exp_last   = (exp.exp_count == 24'h00_0000) ? 24'h00_0000 : exp.exp_count - 24'h00_0001;
   assign fot_last   = (exp.spl == 8'h00) ? 24'h00_0000 : {16'h0000, exp.spl - 8'h01};

   // ==========================================================
   // exposure sequence
   always_comb begin
      start_sync_d = {start_sync_q[1:0], exposure_start_pin};
      req_sync_d   = {req_sync_q[1:0], frame_request_pin};
      state_d      = state_q;
      cyc_d        = tick ? 8'h00 : cyc_q + 8'h01;
      units_d      = tick ? units_q + 24'h00_0001 : units_q;
      pend_d       = pend_q;
      ro_start_d   = 1'b0;
      unique case (state_q)
         EX_IDLE: begin
            cyc_d   = 8'h00;
            units_d = 24'h00_0000;
            pend_d  = 1'b0;
            if (exp.ext_mode ? start_rise : req_rise) begin // see R13
               state_d = EX_EXPOSE;
            end
         end
         EX_EXPOSE: begin
            if (exp.ext_mode) begin
               cyc_d   = 8'h00;
               units_d = 24'h00_0000;
               if (req_rise) begin // see R15 // see R17
                  pend_d = 1'b1;
               end
            end else if (tick && units_q == exp_last) begin // see R14
               pend_d = 1'b1;
            end
            if ((pend_q || pend_d) && !exp.ro_busy) begin
               state_d = EX_FOT;
               cyc_d   = 8'h00;
               units_d = 24'h00_0000;
            end
         end
         EX_FOT: begin
            if (tick && units_q == fot_last) begin // see R16
               state_d    = EX_IDLE;
               ro_start_d = 1'b1;
            end
         end
      endcase
      integ_d = (state_d == EX_EXPOSE);
      fot_d   = (state_d == EX_FOT);
      if (!rstn) begin
         start_sync_d = 3'h0;
         req_sync_d   = 3'h0;
         state_d      = EX_IDLE;
         cyc_d        = 8'h00;
         units_d      = 24'h00_0000;
         pend_d       = 1'b0;
         integ_d      = 1'b0;
         fot_d        = 1'b0;
         ro_start_d   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      start_sync_q <= start_sync_d;
      req_sync_q   <= req_sync_d;
      state_q      <= state_d;
      cyc_q        <= cyc_d;
      units_q      <= units_d;
      pend_q       <= pend_d;
      integ_q      <= integ_d;
      fot_q        <= fot_d;
      ro_start_q   <= ro_start_d;
   end

   assign exp.integrating   = integ_q;
   assign exp.fot_active    = fot_q;
   assign exp.readout_start = ro_start_q;
   assign exp.exp_busy      = (state_q != EX_IDLE);

endmodule : scw_exposure

// [rtl/scw_spi_port.sv]
// serial configuration port, runs on the spi clock
// assumes 16-bit frames, mode 0, and a few sclk edges after rstn release
module scw_spi_port
   import scw_pkg::*;
(
   input  wire logic spi_sclk,
   input  wire logic rstn,
   input  wire logic spi_cs_n,
   input  wire logic spi_mosi,
   output wire logic spi_miso,
   scw_cfg_if.port   cfg
);
   logic [1:0]  rst_sync_q, rst_sync_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [14:0] sh_q, sh_d;
   logic        req_q, req_d;
   logic        wr_q, wr_d;
   logic [6:0]  addr_q, addr_d;
   logic [7:0]  wdata_q, wdata_d;
   logic [1:0]  ack_sync_q, ack_sync_d;
   logic        ack_seen_q, ack_seen_d;
   logic [7:0]  rd_q, rd_d;
   logic        miso_q, miso_d;
   logic [3:0]  rd_idx;

   // ==========================================================
   // frame shifter and crossing
   assign rd_idx = 4'he - cnt_q;

   always_comb begin
      rst_sync_d = {rst_sync_q[0], rstn};
      ack_sync_d = {ack_sync_q[0], cfg.ack_toggle};
      cnt_d      = cnt_q;
      sh_d       = sh_q;
      req_d      = req_q;
      wr_d       = wr_q;
      addr_d     = addr_q;
      wdata_d    = wdata_q;
      ack_seen_d = ack_seen_q;
      rd_d       = rd_q;
      miso_d     = miso_q;
      if (ack_sync_q[1] != ack_seen_q) begin
         ack_seen_d = ack_sync_q[1];
         rd_d       = cfg.rdata;
      end
      if (spi_cs_n) begin
         cnt_d  = 4'h0;
         miso_d = 1'b0;
      end else begin
         cnt_d = cnt_q + 4'h1;
         sh_d  = {sh_q[13:0], spi_mosi};
         if (cnt_q >= SPI_RD_FIRST && cnt_q != SPI_LAST_BIT) begin
            miso_d = rd_q[rd_idx[2:0]];
         end else begin
            miso_d = 1'b0;
         end
         if (cnt_q == SPI_LAST_BIT) begin
            wr_d    = sh_q[14];
            addr_d  = sh_q[13:7];
            wdata_d = {sh_q[6:0], spi_mosi};
            req_d   = ~req_q;
         end
      end
      if (!rst_sync_q[1]) begin
         cnt_d      = 4'h0;
         sh_d       = 15'h0000;
         req_d      = 1'b0;
         wr_d       = 1'b0;
         addr_d     = 7'h00;
         wdata_d    = 8'h00;
         ack_seen_d = 1'b0;
         rd_d       = 8'h00;
         miso_d     = 1'b0;
      end
   end

   always_ff @(posedge spi_sclk) begin
      rst_sync_q <= rst_sync_d;
      ack_sync_q <= ack_sync_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      req_q      <= req_d;
      wr_q       <= wr_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      ack_seen_q <= ack_seen_d;
      rd_q       <= rd_d;
      miso_q     <= miso_d;
   end

   assign cfg.req_toggle = req_q;
   assign cfg.is_write   = wr_q;
   assign cfg.addr       = addr_q;
   assign cfg.wdata      = wdata_q;
   assign spi_miso       = miso_q;

endmodule : scw_spi_port

// [rtl/scw_top.sv]
// control-word generator, training insertion, test pins, register file
// assumes pixel_in comes from array logic on sys_clk, pins are asynchronous
//
// Summary of operation
// R1: bits 0-2 carry data, line, frame valid
// R2: bits 3-5 flag slot, row, fot overhead
// R3: bits 6-7 show both groups integrating
// R4: word width follows pixel width; bit9 one (ctrl_out stays CW_W = 12 bits when 10-bit pixels are selected)
// R5: integration bits low while fot is high
// R6: two test pins each select one status bit
// R7: flag timing stretches with fewer outputs
// R8: idle data channels carry the training word
// R9: training word from programmable 12-bit register
// R10: control lane never carries the training word
// R11: idle control word reads 512
// R12: receiver samples using the valid flags only
// R13: one bit selects internal or external exposure
// R14: internal exposure is 129 times count periods
// R15: external exposure runs between two pin edges
// R16: sample phase length comes from its register
// R17: pin gap of one clock is accepted
// R18: short exposures: small phase length, count one
// R19: 128-pixel bursts with one-period gaps between slots, two-period gaps between rows
// R20: one control word per pixel word
module scw_top
   import scw_pkg::*;
#(
   parameter int N_CH  = 16,
   parameter int PIX_W = 12
)(
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   input  wire logic                    spi_sclk,
   input  wire logic                    spi_cs_n,
   input  wire logic                    spi_mosi,
   output wire logic                    spi_miso,
   input  wire logic                    exposure_start_pin,
   input  wire logic                    frame_request_pin,
   input  wire logic [N_CH*PIX_W-1:0]   pixel_in,
   output wire logic [N_CH*PIX_W-1:0]   data_out,
   output wire logic [CW_W-1:0]         ctrl_out,
   output wire logic                    test_pin_a,
   output wire logic                    test_pin_b
);
   scw_cfg_if cfg ();
   scw_exp_if exp ();

   // ==========================================================
   // sub-blocks
   scw_spi_port u_spi (
      .spi_sclk (spi_sclk),
      .rstn     (rstn),
      .spi_cs_n (spi_cs_n),
      .spi_mosi (spi_mosi),
      .spi_miso (spi_miso),
      .cfg      (cfg)
   );

   scw_exposure u_exp (
      .sys_clk            (sys_clk),
      .rstn               (rstn),
      .exposure_start_pin (exposure_start_pin),
      .frame_request_pin  (frame_request_pin),
      .exp                (exp)
   );

   // ==========================================================
   // test pin selection
   function automatic logic scw_tsel(input logic [CW_W-1:0] cw, input logic [7:0] sel);
      logic bit_sel;
      bit_sel = 1'b0;
      unique case (sel)
         TSEL_INT1: bit_sel = cw[CW_INT1];
         TSEL_INT2: bit_sel = cw[CW_INT2];
         TSEL_DATA_VALID_FLAG: bit_sel = cw[CW_DATA_VALID_FLAG];
         TSEL_LINE_VALID_FLAG: bit_sel = cw[CW_LINE_VALID_FLAG];
         TSEL_FRAME_VALID_FLAG: bit_sel = cw[CW_FRAME_VALID_FLAG];
         default:   bit_sel = 1'b0;
      endcase
      return bit_sel;
   endfunction : scw_tsel

   // ==========================================================
   // register file and config crossing
   logic [2:0]  creq_sync_q, creq_sync_d;
   logic        ack_q, ack_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        exp_src_q, exp_src_d;
   logic [23:0] exp_cnt_q, exp_cnt_d;
   logic [7:0]  spl_q, spl_d;
   logic [11:0] train_q, train_d;
   logic [7:0]  tpa_sel_q, tpa_sel_d;
   logic [7:0]  tpb_sel_q, tpb_sel_d;
   logic [7:0]  out_mode_q, out_mode_d;
   logic [11:0] rows_q, rows_d;
   logic        cfg_evt;
   logic [7:0]  rd_mux;
   logic        ro_busy;

   assign cfg_evt = creq_sync_q[1] ^ creq_sync_q[2];

   always_comb begin
      rd_mux = 8'h00;
      unique case (cfg.addr)
         REG_EXP_SRC:  rd_mux = {7'h00, exp_src_q};
         REG_EXP_CNT0: rd_mux = exp_cnt_q[7:0];
         REG_EXP_CNT1: rd_mux = exp_cnt_q[15:8];
         REG_EXP_CNT2: rd_mux = exp_cnt_q[23:16];
         REG_SPL:      rd_mux = spl_q;
         REG_TRAIN_LO: rd_mux = train_q[7:0];
         REG_TRAIN_HI: rd_mux = {4'h0, train_q[11:8]};
         REG_TPA_SEL:  rd_mux = tpa_sel_q;
         REG_TPB_SEL:  rd_mux = tpb_sel_q;
         REG_OUT_MODE: rd_mux = out_mode_q;
         REG_ROWS_LO:  rd_mux = rows_q[7:0];
         REG_ROWS_HI:  rd_mux = {4'h0, rows_q[11:8]};
         REG_STATUS:   rd_mux = {5'h00, ro_busy, exp.fot_active, exp.exp_busy};
         default:      rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      creq_sync_d = {creq_sync_q[1:0], cfg.req_toggle};
      ack_d       = ack_q;
      rdata_d     = rdata_q;
      exp_src_d   = exp_src_q;
      exp_cnt_d   = exp_cnt_q;
      spl_d       = spl_q;
      train_d     = train_q;
      tpa_sel_d   = tpa_sel_q;
      tpb_sel_d   = tpb_sel_q;
      out_mode_d  = out_mode_q;
      rows_d      = rows_q;
      if (cfg_evt) begin
         ack_d = ~ack_q;
         if (!cfg.is_write) begin
            rdata_d = rd_mux;
         end else begin
            unique case (cfg.addr)
               REG_EXP_SRC:  exp_src_d         = cfg.wdata[0]; // see R13
               REG_EXP_CNT0: exp_cnt_d[7:0]    = cfg.wdata;
               REG_EXP_CNT1: exp_cnt_d[15:8]   = cfg.wdata;
               REG_EXP_CNT2: exp_cnt_d[23:16]  = cfg.wdata;
               REG_SPL:      spl_d             = cfg.wdata; // see R16
               REG_TRAIN_LO: train_d[7:0]      = cfg.wdata; // see R9
               REG_TRAIN_HI: train_d[11:8]     = cfg.wdata[3:0];
               REG_TPA_SEL:  tpa_sel_d         = cfg.wdata; // see R6
               REG_TPB_SEL:  tpb_sel_d         = cfg.wdata;
               REG_OUT_MODE: out_mode_d        = cfg.wdata;
               REG_ROWS_LO:  rows_d[7:0]       = cfg.wdata;
               REG_ROWS_HI:  rows_d[11:8]      = cfg.wdata[3:0];
               default:      rows_d            = rows_q;
            endcase
         end
      end
      if (!rstn) begin
         creq_sync_d = 3'h0;
         ack_d       = 1'b0;
         rdata_d     = 8'h00;
         exp_src_d   = EXP_SRC_RST;
         exp_cnt_d   = EXP_CNT_RST;
         spl_d       = SPL_RST;
         train_d     = TRAIN_RST;
         tpa_sel_d   = TSEL_RST;
         tpb_sel_d   = TSEL_RST;
         out_mode_d  = OUT_MODE_RST;
         rows_d      = ROWS_RST;
      end
   end

   always_ff @(posedge sys_clk) begin
      creq_sync_q <= creq_sync_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      exp_src_q   <= exp_src_d;
      exp_cnt_q   <= exp_cnt_d;
      spl_q       <= spl_d;
      train_q     <= train_d;
      tpa_sel_q   <= tpa_sel_d;
      tpb_sel_q   <= tpb_sel_d;
      out_mode_q  <= out_mode_d;
      rows_q      <= rows_d;
   end

   assign cfg.ack_toggle = ack_q;
   assign cfg.rdata      = rdata_q;
   assign exp.ext_mode   = exp_src_q;
   assign exp.exp_count  = exp_cnt_q;
   assign exp.spl        = spl_q;
   assign exp.ro_busy    = ro_busy;

   // ==========================================================
   // read-out sequencer
   scw_ro_state_t ro_state_q, ro_state_d;
   logic [6:0]  pix_q, pix_d;
   logic [2:0]  slot_q, slot_d;
   logic [2:0]  slot_last_q, slot_last_d;
   logic        wide_q, wide_d;
   logic [11:0] row_q, row_d;
   logic [11:0] rows_last;
   logic [1:0]  mux_sel;
   logic [2:0]  slot_last_new;

   assign ro_busy   = (ro_state_q != RO_IDLE);
   assign rows_last = (rows_q == 12'h000) ? 12'h000 : rows_q - 12'h001;

   always_comb begin
      mux_sel = out_mode_q[OM_MUX_LSB+1:OM_MUX_LSB];
      if (out_mode_q[OM_WIDTH12] && mux_sel < 2'h2) begin
         mux_sel = 2'h2;
      end
      unique case (mux_sel) // see R7
         2'h0: slot_last_new = 3'h0;
         2'h1: slot_last_new = 3'h1;
         2'h2: slot_last_new = 3'h3;
         2'h3: slot_last_new = 3'h7;
      endcase
   end

   always_comb begin
      ro_state_d  = ro_state_q;
      pix_d       = pix_q;
      slot_d      = slot_q;
      slot_last_d = slot_last_q;
      wide_d      = wide_q;
      row_d       = row_q;
      unique case (ro_state_q)
         RO_IDLE: begin
            if (exp.readout_start) begin
               ro_state_d  = RO_ROW;
               row_d       = 12'h000;
               slot_last_d = slot_last_new;
               wide_d      = out_mode_q[OM_WIDTH12];
            end
         end
         RO_ROW: begin
            ro_state_d = RO_SLOT;
            slot_d     = 3'h0;
         end
         RO_SLOT: begin
            ro_state_d = RO_BURST; // see R19
            pix_d      = 7'h00;
         end
         RO_BURST: begin
            pix_d = pix_q + 7'h01;
            if (pix_q == BURST_LAST) begin
               if (slot_q != slot_last_q) begin // see R7
                  slot_d     = slot_q + 3'h1;
                  ro_state_d = RO_SLOT;
               end else if (row_q == rows_last) begin
                  ro_state_d = RO_IDLE;
               end else begin
                  row_d      = row_q + 12'h001;
                  ro_state_d = RO_ROW;
               end
            end
         end
      endcase
      if (!rstn) begin
         ro_state_d  = RO_IDLE;
         pix_d       = 7'h00;
         slot_d      = 3'h0;
         slot_last_d = 3'h0;
         wide_d      = 1'b0;
         row_d       = 12'h000;
      end
   end

   always_ff @(posedge sys_clk) begin
      ro_state_q  <= ro_state_d;
      pix_q       <= pix_d;
      slot_q      <= slot_d;
      slot_last_q <= slot_last_d;
      wide_q      <= wide_d;
      row_q       <= row_d;
   end

   // ==========================================================
   // control word, data lanes and test pins
   logic [CW_W-1:0]       cw_d, cw_q;
   logic [N_CH*PIX_W-1:0] data_d, data_q;
   logic                  tpa_d, tpa_q, tpb_d, tpb_q;
   logic [PIX_W-1:0]      train_word;

   always_comb begin
      cw_d           = CW_CONST; // see R4 // see R11
      cw_d[CW_DATA_VALID_FLAG]  = (ro_state_q == RO_BURST); // see R1
      cw_d[CW_LINE_VALID_FLAG]  = (ro_state_q == RO_BURST) || (ro_state_q == RO_SLOT);
      cw_d[CW_FRAME_VALID_FLAG]  = ro_busy;
      cw_d[CW_SLOT]  = (ro_state_q == RO_SLOT); // see R2
      cw_d[CW_ROW]   = (ro_state_q == RO_ROW);
      cw_d[CW_FOT]   = exp.fot_active;
      cw_d[CW_INT1]  = exp.integrating & ~exp.fot_active; // see R3 // see R5
      cw_d[CW_INT2]  = exp.integrating & ~exp.fot_active;
      tpa_d          = scw_tsel(cw_d, tpa_sel_q); // see R6
      tpb_d          = scw_tsel(cw_d, tpb_sel_q);
      train_word     = wide_q ? train_q : {2'b00, train_q[9:0]}; // see R9
      if (!rstn) begin
         cw_d  = CW_CONST;
         tpa_d = 1'b0;
         tpb_d = 1'b0;
      end
   end

   for (genvar ch = 0; ch < N_CH; ch++) begin : g_lane
      always_comb begin
         if (!rstn) begin
            data_d[ch*PIX_W +: PIX_W] = '0;
         end else if (cw_d[CW_DATA_VALID_FLAG]) begin
            data_d[ch*PIX_W +: PIX_W] = wide_q ? pixel_in[ch*PIX_W +: PIX_W]
                                               : {2'b00, pixel_in[ch*PIX_W +: 10]};
         end else begin
            data_d[ch*PIX_W +: PIX_W] = train_word; // see R8
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      cw_q   <= cw_d; // see R10 // see R20
      data_q <= data_d;
      tpa_q  <= tpa_d;
      tpb_q  <= tpb_d;
   end

   assign ctrl_out   = cw_q;
   assign data_out   = data_q;
   assign test_pin_a = tpa_q;
   assign test_pin_b = tpb_q;

endmodule : scw_top

// [test/scw_properties.sv]
// checker on the top ports: control word, lanes, pin a
// assumes bind into scw_top, one clock domain
module scw_properties
   import scw_pkg::*;
#(parameter int N_CH = 16, parameter int PIX_W = 12)(
   input wire logic                  sys_clk,
   input wire logic                  rstn,
   input wire logic [N_CH*PIX_W-1:0] data_out,
   input wire logic [CW_W-1:0]       ctrl_out,
   input wire logic                  test_pin_a
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // burst run length
   logic [7:0] run_q, run_d;
   always_comb run_d = ctrl_out[CW_DATA_VALID_FLAG] ? run_q + 8'h01 : 8'h00;
   always_ff @(posedge sys_clk) run_q <= rstn ? run_d : 8'h00;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_fixed_bits: assert property (ctrl_out[11:8] == 4'h2) else $error("fixed bits");
   a_int_fot: assert property (ctrl_out[CW_FOT] |-> ctrl_out[7:6] == 2'h0) else $error("int in fot");
   a_data_valid_flag_line: assert property (ctrl_out[CW_DATA_VALID_FLAG] |-> ctrl_out[CW_LINE_VALID_FLAG] && ctrl_out[CW_FRAME_VALID_FLAG])
      else $error("data_valid_flag alone");
   a_idle_lanes: assert property (!ctrl_out[CW_DATA_VALID_FLAG] |-> data_out == {N_CH{data_out[PIX_W-1:0]}})
      else $error("idle lanes");
   a_pin_a_src: assert property (test_pin_a |-> |{ctrl_out[7:6], ctrl_out[2:0]}) else $error("pin a");
   a_slot_burst: assert property (ctrl_out[CW_SLOT] |=> (ctrl_out[CW_DATA_VALID_FLAG] && !ctrl_out[CW_SLOT]) [*8])
      else $error("slot");
   a_burst_len: assert property ($fell(ctrl_out[CW_DATA_VALID_FLAG]) |-> run_q == 8'h80) else $error("burst");
   a_row_first: assert property ($rose(ctrl_out[CW_FRAME_VALID_FLAG]) |-> ctrl_out[CW_ROW]) else $error("row");
endmodule : scw_properties
bind scw_top scw_properties #(.N_CH(N_CH), .PIX_W(PIX_W)) u_props (.sys_clk(sys_clk), .rstn(rstn),
   .data_out(data_out), .ctrl_out(ctrl_out), .test_pin_a(test_pin_a));

// [test/scw_rx_model.sv]
// receiver model: takes lane words on the valid flags alone
// assumes registered control and lane words on sys_clk
module scw_rx_model
   import scw_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            clr,
   input  wire logic [CW_W-1:0] ctrl_out,
   input  wire logic [11:0]     lane0,
   output logic      [15:0]     n_pix,
   output logic      [11:0]     pix
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // sampling
   always @(posedge sys_clk) begin
      if (clr) begin
         n_pix <= 16'h0000;
      end else if (ctrl_out[CW_DATA_VALID_FLAG] && ctrl_out[CW_LINE_VALID_FLAG] && ctrl_out[CW_FRAME_VALID_FLAG]) begin
         n_pix <= n_pix + 16'h0001;
         pix   <= lane0;
      end
   end
endmodule : scw_rx_model

// [test/scw_top_tb.sv]
// self-checking bench of the control-word block
// assumes scw_top with bound checker and receiver model
module scw_top_tb
   import scw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // stimulus and monitor
   logic         sys_clk = 0, rstn = 0, sclk = 0, cs_n = 1, mosi = 0, st = 0, rq = 0, clr = 0, miso, pa, pb;
   logic [191:0] dout;
   logic [11:0]  ctrl, pix;
   logic [15:0]  n_pix;
   int           err_count = 0, checked = 0, cyc = 0, n_int, n_fot, n_pa, n_pb;
   scw_top dut (.sys_clk(sys_clk), .rstn(rstn), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .exposure_start_pin(st), .frame_request_pin(rq), .pixel_in({16{12'h0c3}}),
      .data_out(dout), .ctrl_out(ctrl), .test_pin_a(pa), .test_pin_b(pb));
   scw_rx_model rx (.sys_clk(sys_clk), .clr(clr), .ctrl_out(ctrl), .lane0(dout[11:0]), .n_pix(n_pix), .pix(pix));
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      n_int += ctrl[CW_INT1];
      n_fot += ctrl[CW_FOT];
      n_pa += pa;
      n_pb += pb;
      if (cyc == 20000) begin
         err_count++;
         end_sim;
      end
   end
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic pulse;
      #62.5 sclk = 1;
      #62.5 sclk = 0;
   endtask : pulse
   task automatic spi(input logic [15:0] w, output logic [7:0] r);
      cs_n = 0;
      for (int i = 15; i >= 0; i--) begin
         mosi = w[i];
         pulse;
         if (i inside {[1:8]}) r = {r[6:0], miso};
      end
      cs_n = 1;
      #250;
   endtask : spi
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi({1'b1, a, d}, r);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] r;
      spi({1'b0, a, 8'h00}, r);
      spi(16'h0000, r);
      chk("register", {8'h00, e}, {8'h00, r});
   endtask : rd
   task automatic frame(input logic ext, input logic [15:0] np);
      bit seen;
      seen = 0;
      @(negedge sys_clk);
      clr = 1;
      n_int = 0;
      n_fot = 0;
      n_pa = 0;
      n_pb = 0;
      @(negedge sys_clk);
      clr = 0;
      st = ext;
      @(negedge sys_clk);
      rq = 1;
      for (int i = 0; i < 4000 && !(seen && !ctrl[CW_FRAME_VALID_FLAG]); i++) begin
         @(negedge sys_clk);
         seen |= ctrl[CW_FRAME_VALID_FLAG];
      end
      st = 0;
      rq = 0;
      chk("fot cycles", 16'h050a, n_fot);
      chk("pixels", np, n_pix);
      chk("pixel word", 16'h00c3, {4'h0, pix});
   endtask : frame
   task automatic t_regs;
      rd(REG_EXP_SRC, 8'h00);
      rd(REG_EXP_CNT1, 8'h08);
      rd(REG_SPL, 8'h0a);
      rd(7'h00, 8'h00);
      $display("register defaults done");
   endtask : t_regs
   task automatic t_internal;
      wr(REG_ROWS_LO, 8'h01);
      wr(REG_ROWS_HI, 8'h00);
      wr(REG_EXP_CNT0, 8'h01);
      wr(REG_EXP_CNT1, 8'h00);
      wr(REG_TRAIN_LO, 8'h5a);
      wr(REG_TRAIN_HI, 8'h01);
      wr(REG_TPA_SEL, TSEL_DATA_VALID_FLAG);
      chk("idle lane", 16'h015a, {4'h0, dout[11:0]});
      chk("idle word", 16'h0200, {4'h0, ctrl});
      frame(0, 16'h0080);
      chk("int cycles", 16'h0081, n_int);
      chk("pin a", 16'h0080, n_pa);
      chk("pin b", 16'h0081, n_pb);
      $display("internal exposure done");
   endtask : t_internal
   task automatic t_external;
      wr(REG_EXP_SRC, 8'h01);
      wr(REG_TPA_SEL, TSEL_INT2);
      wr(REG_OUT_MODE, 8'h04);
      frame(1, 16'h0200);
      chk("int cycles", 16'h0001, n_int);
      chk("pin a", 16'h0001, n_pa);
      $display("external exposure done");
   endtask : t_external
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   initial begin
      repeat (4) pulse;
      repeat (20) @(negedge sys_clk);
      rstn = 1;
      repeat (3) pulse;
      t_regs;
      t_internal;
      t_external;
      end_sim;
   end
endmodule : scw_top_tb
